// ===== src/hfa_pkg.sv
package hfa_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FIFO_LAST = 8'h1f; // last index of the fifo window
    localparam logic [7:0] IDX_INTERRUPT_FLAGS = 8'h20;      // interrupt_flags, read side
    localparam logic [7:0] IDX_MASK = 8'h20;      // interrupt mask, write side
    localparam logic [7:0] IDX_STATUS_REG = 8'h21;      // status_reg, read side
    localparam logic [7:0] IDX_COMMAND_REG = 8'h21;      // command_reg, write side
    localparam logic [7:0] IDX_RX_BYTE_COUNT_LOW = 8'h25;      // rx_byte_count_low
    localparam logic [7:0] IDX_RX_FRAME_STATUS = 8'h27;      // rx_frame_status
    localparam logic [7:0] IDX_RX_BYTE_COUNT_HIGH = 8'h2a;      // rx_byte_count_high
    localparam logic [7:0] IDX_MASK_RD = 8'h2c;   // mask read-back
    localparam logic [7:0] IDX_INTERRUPT_FLAGS_W1C = 8'h2e;  // write-one-to-clear alias of the flags

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int INTERRUPT_FLAGS_RME = 7;  // receive_message_end
    localparam int INTERRUPT_FLAGS_RPF = 6;  // receive_pool_full
    localparam int INTERRUPT_FLAGS_RSC = 5;  // remote_status_change
    localparam int INTERRUPT_FLAGS_XPR = 4;  // transmit_pool_ready
    localparam int STATUS_REG_XDOV = 7; // transmit data overflow
    localparam int STATUS_REG_XFW = 6;  // transmit fifo write enable
    localparam int STATUS_REG_XRNR = 5; // own receiver not ready
    localparam int STATUS_REG_REMOTE_NOT_READY = 4; // remote_not_ready
    localparam int STATUS_REG_MBR = 3;  // receive buffer free
    localparam int CMD_RMC = 7;   // receive_message_complete
    localparam int CMD_RRES = 6;  // receiver reset
    localparam int CMD_RNR = 5;   // own receiver not ready
    localparam int CMD_XTF = 3;   // transmit transparent frame
    localparam int CMD_XIF = 2;   // transmit i-frame
    localparam int CMD_XME = 1;   // transmit message end
    localparam int CMD_XRES = 0;  // transmitter reset
    localparam int RX_FRAME_STATUS_RDO = 6;  // receive data overflow

    // ------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] INTERRUPT_FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STATUS_REG_RST = 8'h48;
    localparam int FIFO_BYTES = 32;
    localparam int CNT_W = 12; // frame byte counter width

endpackage

// ===== src/hfa_rx_if.sv
`timescale 1ns/1ps
// link between register front end and receive pool
interface hfa_rx_if;
    logic rd_strobe;        // one completed fifo window read
    logic receive_message_complete;              // receive_message_complete command
    logic rres;             // receiver reset command
    logic [7:0] rd_data;    // byte at the read pointer
    logic rpf_evt;          // receive_pool_full event pulse
    logic rme_evt;          // receive_message_end event pulse
    logic pool_free;        // pool accepts bytes
    logic [hfa_pkg::CNT_W-1:0] byte_cnt; // frame length at message end
    logic [7:0] frame_stat; // frame status at message end

    modport ctl (output rd_strobe, output receive_message_complete, output rres, input rd_data, input rpf_evt,
                 input rme_evt, input pool_free, input byte_cnt, input frame_stat);
    modport pool (input rd_strobe, input receive_message_complete, input rres, output rd_data, output rpf_evt,
                  output rme_evt, output pool_free, output byte_cnt, output frame_stat);
endinterface

// ===== src/hfa_rx_pool.sv
`timescale 1ns/1ps
module hfa_rx_pool #(
    parameter int DEPTH = hfa_pkg::FIFO_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic [7:0] rx_frame_stat,
    hfa_rx_if.pool bus
);
    localparam int PW = $clog2(DEPTH);

    // the pointers wrap naturally, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("hfa_rx_pool: DEPTH must be a power of two");
    end

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HFA_RX_FILL = 2'b01, // receiver fills the pool
        HFA_RX_HELD = 2'b10  // pool waits for the processor
    } hfa_rx_state_t;

    hfa_rx_state_t state;
    logic [7:0] mem [DEPTH];             // pool bytes
    logic [PW-1:0] wptr;                 // receiver write position
    logic [PW-1:0] rptr;                 // processor read position
    logic [hfa_pkg::CNT_W-1:0] frame_cnt; // bytes of the current frame
    logic end_pending;                   // frame ended while pool was held
    logic overflow;                      // bytes lost while held
    logic frame_done;                    // last pool of a frame is held

    wire logic take = rx_byte_valid && state == HFA_RX_FILL;
    wire logic fills = take && wptr == PW'(DEPTH - 1);

    // ------------------------------------------------------------
    // byte storage and processor read path
    // ------------------------------------------------------------
    // bytes enter the pool only while it is filling
    always_ff @(posedge clk) begin
        if (take) begin
            mem[wptr] <= rx_byte;
        end
    end

    assign bus.rd_data = mem[rptr];

    // read pointer steps once per completed read, restarts with a new pool
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rptr <= '0;
        end else if (bus.rres || bus.receive_message_complete) begin
            rptr <= '0;
        end else if (bus.rd_strobe) begin
            rptr <= rptr + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pool state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= HFA_RX_FILL;
            wptr <= '0;
            frame_cnt <= '0;
            end_pending <= 1'b0;
            overflow <= 1'b0;
            frame_done <= 1'b0;
            bus.rpf_evt <= 1'b0;
            bus.rme_evt <= 1'b0;
            bus.byte_cnt <= '0;
            bus.frame_stat <= 8'h00;
        end else begin
            bus.rpf_evt <= 1'b0;
            bus.rme_evt <= 1'b0;
            if (bus.rres) begin
                // receiver reset drops everything held
                state <= HFA_RX_FILL;
                wptr <= '0;
                frame_cnt <= '0;
                end_pending <= 1'b0;
                overflow <= 1'b0;
                frame_done <= 1'b0;
            end else begin
                case (state)
                    HFA_RX_FILL: begin
                        if (take) begin
                            wptr <= wptr + 1'b1;
                            frame_cnt <= frame_cnt + 1'b1;
                        end
                        if (rx_frame_end) begin
                            // whole short frame or last part is in the pool
                            state <= HFA_RX_HELD;
                            frame_done <= 1'b1;
                            bus.rme_evt <= 1'b1;
                            bus.byte_cnt <= frame_cnt + hfa_pkg::CNT_W'(take);
                            bus.frame_stat <= rx_frame_stat | (8'(overflow) << hfa_pkg::RX_FRAME_STATUS_RDO);
                        end else if (fills) begin
                            // exactly one full pool, frame still running
                            state <= HFA_RX_HELD;
                            bus.rpf_evt <= 1'b1;
                        end
                    end
                    HFA_RX_HELD: begin
                        // bytes arriving now have no room; flag the loss
                        if (rx_byte_valid) begin
                            overflow <= 1'b1;
                            frame_cnt <= frame_cnt + 1'b1;
                        end
                        if (rx_frame_end && !frame_done) begin
                            end_pending <= 1'b1;
                            bus.byte_cnt <= frame_cnt + hfa_pkg::CNT_W'(rx_byte_valid);
                            bus.frame_stat <= rx_frame_stat | 8'h40;
                        end
                        if (bus.receive_message_complete) begin
                            // processor has fetched the pool, release it
                            wptr <= '0;
                            if (end_pending) begin
                                // frame ended on a pool boundary: empty last part
                                end_pending <= 1'b0;
                                frame_done <= 1'b1;
                                bus.rme_evt <= 1'b1;
                            end else begin
                                state <= HFA_RX_FILL;
                                if (frame_done) begin
                                    frame_cnt <= '0;
                                    overflow <= 1'b0;
                                    frame_done <= 1'b0;
                                end
                            end
                        end
                    end
                    default: begin
                        state <= HFA_RX_FILL;
                    end
                endcase
            end
        end
    end

    // free flag is a flop so that the top output stays registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus.pool_free <= 1'b1;
        end else begin
            bus.pool_free <= (state == HFA_RX_FILL) && !rx_frame_end && !fills && !bus.receive_message_complete;
        end
    end

endmodule

// ===== src/hfa_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module hfa_top #(
    parameter int FIFO_BYTES = hfa_pkg::FIFO_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // receiver side
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic [7:0] rx_frame_stat,
    output logic rx_ready,
    input wire logic auto_mode,
    input wire logic sframe_valid,
    input wire logic sframe_rnr,
    // transmitter side
    input wire logic [4:0] tx_rd_addr,
    output logic [7:0] tx_rd_data,
    output logic tx_start,
    output logic tx_iframe,
    output logic tx_end,
    output logic [5:0] tx_len,
    output logic tx_abort,
    output logic own_rnr,
    input wire logic tx_pool_done
);
    localparam int PW = $clog2(FIFO_BYTES);

    // the window decode and the 5-bit transmitter address assume 32 bytes
    if (FIFO_BYTES != 32) begin : g_bad_size
        $error("hfa_top: FIFO_BYTES must be 32");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // register index from a byte address
    function automatic logic [7:0] reg_idx(input logic [9:0] addr);
        return addr[9:2];
    endfunction

    // index falls in the 32-entry fifo window
    function automatic logic in_window(input logic [7:0] idx);
        return idx <= hfa_pkg::IDX_FIFO_LAST;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    hfa_rx_if rx_bus ();

    logic [7:0] idx;           // decoded register index
    logic done;                // transfer completes this edge
    logic rd_done;             // completed read
    logic wr_done;             // completed write
    logic [7:0] next_rdata;    // read mux result
    logic rd_mapped;           // read index exists
    logic wr_mapped;           // write index exists
    logic [7:0] interrupt_flags;          // interrupt_flags storage
    logic [7:0] mask;          // 1 = source masked
    logic [7:0] ev;            // event pulses into the flags
    logic [7:0] clr;           // clear vector from software
    logic [7:0] rx_byte_count_low;          // rx_byte_count_low
    logic [7:0] rx_byte_count_high;          // rx_byte_count_high
    logic [7:0] rx_frame_status;          // rx_frame_status
    logic remote_not_ready;                // remote_not_ready
    logic xfw;                 // transmit pool writable
    logic xdov;                // transmit pool overrun
    logic xrnr;                // own receiver not ready
    logic [7:0] tx_mem [FIFO_BYTES]; // transmit pool
    logic [PW-1:0] tx_wptr;    // processor write position
    logic [5:0] tx_cnt;        // bytes written into the pool
    logic cmd_wr;              // command register written
    logic xpr_evt;             // transmit pool ready event
    logic rsc_evt;             // remote status change event

    assign idx = reg_idx(paddr);
    assign done = psel && penable && pready;
    assign rd_done = done && !pwrite;
    assign wr_done = done && pwrite;
    assign cmd_wr = wr_done && idx == hfa_pkg::IDX_COMMAND_REG;

    // read mux; masked flags stay hidden but pending
    always_comb begin
        next_rdata = 8'h00;
        rd_mapped = 1'b1;
        if (in_window(idx)) begin
            next_rdata = rx_bus.rd_data;
        end else begin
            case (idx)
                hfa_pkg::IDX_INTERRUPT_FLAGS: next_rdata = interrupt_flags & ~mask;
                hfa_pkg::IDX_STATUS_REG: begin
                    next_rdata = 8'h00;
                    next_rdata[hfa_pkg::STATUS_REG_XDOV] = xdov;
                    next_rdata[hfa_pkg::STATUS_REG_XFW] = xfw;
                    next_rdata[hfa_pkg::STATUS_REG_XRNR] = xrnr;
                    next_rdata[hfa_pkg::STATUS_REG_REMOTE_NOT_READY] = remote_not_ready;
                    next_rdata[hfa_pkg::STATUS_REG_MBR] = rx_bus.pool_free;
                end
                hfa_pkg::IDX_RX_BYTE_COUNT_LOW: next_rdata = rx_byte_count_low;
                hfa_pkg::IDX_RX_BYTE_COUNT_HIGH: next_rdata = rx_byte_count_high;
                hfa_pkg::IDX_RX_FRAME_STATUS: next_rdata = rx_frame_status;
                hfa_pkg::IDX_MASK_RD: next_rdata = mask;
                default: rd_mapped = 1'b0;
            endcase
        end
    end

    // writable indices
    always_comb begin
        wr_mapped = in_window(idx) || idx == hfa_pkg::IDX_MASK || idx == hfa_pkg::IDX_COMMAND_REG
            || idx == hfa_pkg::IDX_INTERRUPT_FLAGS_W1C;
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // one wait state so that read data comes from a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            // read data stands until the next read answer; writes leave it alone
            if (!pwrite) begin
                prdata <= {24'h00_0000, next_rdata};
            end
            pslverr <= pwrite ? !wr_mapped : !rd_mapped;
        end else begin
            pready <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // receive pool
    // ------------------------------------------------------------
    // side effects act only at the completing edge, never on the wait state
    assign rx_bus.rd_strobe = rd_done && in_window(idx) && !pslverr;
    assign rx_bus.receive_message_complete = cmd_wr && pwdata[hfa_pkg::CMD_RMC];
    assign rx_bus.rres = cmd_wr && pwdata[hfa_pkg::CMD_RRES];
    assign rx_ready = rx_bus.pool_free;

    hfa_rx_pool #(
        .DEPTH(FIFO_BYTES)
    ) u_rx_pool (
        .clk(clk),
        .rst_n(rst_n),
        .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte),
        .rx_frame_end(rx_frame_end),
        .rx_frame_stat(rx_frame_stat),
        .bus(rx_bus)
    );

    // length and status latched at message end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_byte_count_low <= 8'h00;
            rx_byte_count_high <= 8'h00;
            rx_frame_status <= 8'h00;
        end else if (rx_bus.rme_evt) begin
            rx_byte_count_low <= rx_bus.byte_cnt[7:0];
            rx_byte_count_high <= {4'h0, rx_bus.byte_cnt[11:8]};
            rx_frame_status <= rx_bus.frame_stat;
        end
    end

    // ------------------------------------------------------------
    // remote receiver state
    // ------------------------------------------------------------
    // supervisory frames only count in auto-mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remote_not_ready <= 1'b0;
            rsc_evt <= 1'b0;
        end else begin
            rsc_evt <= 1'b0;
            if (auto_mode && sframe_valid && sframe_rnr != remote_not_ready) begin
                remote_not_ready <= sframe_rnr;
                rsc_evt <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt flags and mask
    // ------------------------------------------------------------
    always_comb begin
        ev = 8'h00;
        ev[hfa_pkg::INTERRUPT_FLAGS_RME] = rx_bus.rme_evt;
        ev[hfa_pkg::INTERRUPT_FLAGS_RPF] = rx_bus.rpf_evt;
        ev[hfa_pkg::INTERRUPT_FLAGS_RSC] = rsc_evt;
        ev[hfa_pkg::INTERRUPT_FLAGS_XPR] = xpr_evt;
        // clear only what was shown on the read, so a later set is not lost
        clr = 8'h00;
        if (rd_done && idx == hfa_pkg::IDX_INTERRUPT_FLAGS) begin
            clr = prdata[7:0];
        end
        if (wr_done && idx == hfa_pkg::IDX_INTERRUPT_FLAGS_W1C) begin
            clr = clr | pwdata[7:0];
        end
    end

    // set wins over clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interrupt_flags <= hfa_pkg::INTERRUPT_FLAGS_RST;
        end else begin
            interrupt_flags <= (interrupt_flags & ~clr) | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask <= hfa_pkg::MASK_RST;
        end else if (wr_done && idx == hfa_pkg::IDX_MASK) begin
            mask <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((interrupt_flags & ~clr) | ev) & ~mask);
        end
    end

    // ------------------------------------------------------------
    // transmit pool
    // ------------------------------------------------------------
    // bytes land at the write pointer; the 33rd byte wraps and overwrites
    always_ff @(posedge clk) begin
        if (wr_done && in_window(idx) && xfw) begin
            tx_mem[tx_wptr] <= pwdata[7:0];
        end
        tx_rd_data <= tx_mem[tx_rd_addr];
    end

    // pointer, write enable and handover to the transmitter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_wptr <= '0;
            tx_cnt <= 6'h00;
            xfw <= 1'b1;
            xdov <= 1'b0;
            xrnr <= 1'b0;
            xpr_evt <= 1'b0;
            tx_start <= 1'b0;
            tx_iframe <= 1'b0;
            tx_end <= 1'b0;
            tx_len <= 6'h00;
            tx_abort <= 1'b0;
        end else begin
            xpr_evt <= 1'b0;
            tx_start <= 1'b0;
            tx_abort <= 1'b0;
            if (cmd_wr) begin
                xrnr <= pwdata[hfa_pkg::CMD_RNR];
            end
            if (cmd_wr && pwdata[hfa_pkg::CMD_XRES]) begin
                // abort: empty the pool and hand it back at once
                tx_wptr <= '0;
                tx_cnt <= 6'h00;
                xfw <= 1'b1;
                xdov <= 1'b0;
                xpr_evt <= 1'b1;
                tx_abort <= 1'b1;
            end else if (cmd_wr && xfw && (pwdata[hfa_pkg::CMD_XTF]
                    || (pwdata[hfa_pkg::CMD_XIF] && auto_mode))) begin
                // hand the pool over; the next pool starts at the top
                tx_start <= 1'b1;
                tx_iframe <= pwdata[hfa_pkg::CMD_XIF] && !pwdata[hfa_pkg::CMD_XTF];
                tx_end <= pwdata[hfa_pkg::CMD_XME];
                tx_len <= tx_cnt;
                xfw <= 1'b0;
                tx_wptr <= '0;
                tx_cnt <= 6'h00;
            end else if (wr_done && in_window(idx) && xfw) begin
                tx_wptr <= tx_wptr + 1'b1;
                if (tx_cnt == 6'(FIFO_BYTES)) begin
                    xdov <= 1'b1;
                end else begin
                    tx_cnt <= tx_cnt + 1'b1;
                end
            end else if (tx_pool_done && !xfw) begin
                xfw <= 1'b1;
                xdov <= 1'b0;
                xpr_evt <= 1'b1;
            end
        end
    end

    assign own_rnr = xrnr;

endmodule

// ===== testbench/hfa_cpu.sv
`timescale 1ns/1ps
// ----
// processor model, apb master
// ----
module hfa_cpu (
    input logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr
);
    logic err; // error of the last transfer
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
    end
    // waits an edge first so a release never meets a new request in one step
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata; // stale data is not left on the bus
    endtask
endmodule

// ===== testbench/hfa_top_props.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module hfa_props (
    input logic clk,
    input logic rst_n,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [9:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic irq,
    input logic rx_ready,
    input logic tx_start,
    input logic [5:0] tx_len
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // completed command write that frees the receive pool
    logic rmc_wr;
    assign rmc_wr = psel && penable && pready && pwrite && paddr[9:2] == 8'h21 && pwdata[7];
    property p_rst; $rose(rst_n) |-> !irq && !pready; endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_cause; pready |-> $past(penable); endproperty
    a_cause: assert property (p_cause) else $error("stray ready");
    property p_rd; $changed(prdata) |-> pready && !pwrite; endproperty
    a_rd: assert property (p_rd) else $error("read data moved");
    property p_rmc; rmc_wr |-> ##[1:3] rx_ready; endproperty
    a_rmc: assert property (p_rmc) else $error("pool not freed");
    property p_tx; tx_start |-> tx_len <= 6'd32 ##1 !tx_start; endproperty
    a_tx: assert property (p_tx) else $error("bad start");
    property p_full; $fell(rx_ready) |-> ##[0:3] irq; endproperty
    a_full: assert property (p_full) else $error("no irq on held pool");
    c_full: cover property ($fell(rx_ready));
    c_tx: cover property (tx_start);
    c_irq: cover property ($rose(irq));
endmodule
bind hfa_top hfa_props u_props (.*);

// ===== testbench/tb_hdlc_fifo_host_access.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
// ----
// host access bench
// ----
module tb_hdlc_fifo_host_access;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, rx_ready, tx_start, tx_iframe, tx_end, tx_abort, own_rnr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rx_byte = 8'h00, rx_frame_stat = 8'h00, tx_rd_data, q;
    logic rx_byte_valid = 1'b0, rx_frame_end = 1'b0, auto_mode = 1'b0, sframe_valid = 1'b0, sframe_rnr = 1'b0;
    logic tx_pool_done = 1'b0;
    logic [4:0] tx_rd_addr = 5'd0;
    logic [5:0] tx_len;
    int fails = 0, cmp_count = 0, cyc = 0, n_start = 0;
    hfa_top DUT (.*);
    hfa_cpu cpu (.*);
    always #12.5 clk = ~clk;
    // hang ceiling and start pulse count
    always @(posedge clk) begin
        cyc++;
        n_start += int'(tx_start === 1'b1);
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        cpu.xfer(1'b0, idx, 8'h00, q);
        `CHK("rd", e, q)
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        cpu.xfer(1'b1, idx, d, q);
    endtask
    // feeds n bytes counting up from b, end marked on the last one if fin
    task automatic rx(input int n, input logic [7:0] b, input logic fin);
        for (int i = 0; i < n; i++) begin
            rx_byte_valid <= 1'b1;
            rx_byte <= b + 8'(i);
            rx_frame_end <= fin && i == n - 1;
            @(posedge clk);
        end
        rx_byte_valid <= 1'b0;
        rx_frame_end <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h48);
        $display("reset test done");
        rx(32, 8'h10, 1'b0);
        `CHK("irq", 1'b1, irq)
        rd(8'h20, 8'h40);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 32; i++) rd(8'(i * 7 % 32), 8'h10 + 8'(i));
        wr(8'h21, 8'h80);
        rx(3, 8'h30, 1'b1);
        rd(8'h20, 8'h80);
        rd(8'h25, 8'h23);
        rd(8'h2a, 8'h00);
        rd(8'h05, 8'h30);
        wr(8'h21, 8'h80);
        $display("receive test done");
        for (int i = 0; i < 3; i++) wr(8'(i + 9), 8'ha0 + 8'(i));
        wr(8'h21, 8'h2a);
        tx_rd_addr <= 5'd2;
        repeat (3) @(posedge clk);
        `CHK("tx_len", 6'd3, tx_len)
        `CHK("tx_data", 8'ha2, tx_rd_data)
        `CHK("starts", 1, n_start)
        `CHK("tx_end", 1'b1, tx_end)
        `CHK("tx_iframe", 1'b0, tx_iframe)
        `CHK("own_rnr", 1'b1, own_rnr)
        tx_pool_done <= 1'b1;
        @(posedge clk);
        tx_pool_done <= 1'b0;
        rd(8'h20, 8'h10);
        $display("transmit test done");
        auto_mode <= 1'b1;
        wr(8'h20, 8'h20);
        sframe_rnr <= 1'b1;
        sframe_valid <= 1'b1;
        @(posedge clk);
        sframe_valid <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rd(8'h21, 8'h78);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h20);
        cpu.xfer(1'b0, 8'h30, 8'h00, q);
        `CHK("err", 1'b1, cpu.err)
        $display("status test done");
        test_done();
    end
endmodule
